// [core/otfs_top.sv]
`timescale 1ns/1ns
// Contract
// R01: Each terminal has own selector; sharing allowed
// R02: Reset: relay a running, relay b fault
// R03: Code 34 mirrors fieldbus virtual output bit
// R04: Code 36 shows speed/position switch-over done
// R05: Code 37: ramp frequency above detection value
// R06: Codes 41-47 pass card outputs in order
// R07: Code 48: PT100 card overheat pre-alarm
// R08: Code 49: PT1000 card overheat pre-alarm
// R09: Code 50: analog channel overheat pre-alarm
// R10: Code 51: stopped or zero speed
// R11: Code 52: disconnection, only when detection enabled
// R12: Code 53: roll diameter setpoint, tension running
// R13: Code 54: max roll diameter, tension running
// R14: Code 55: min roll diameter, tension running
// R15: Code 56: fire mode on
// R16: Reserved codes drive terminal off
module otfs_top
#(
  parameter int unsigned TERMS  = otfs_pkg::TERM_N,
  parameter int unsigned FREQ_W = otfs_pkg::FREQ_W
)
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  // Selector programming
  input  wire logic                 sel_wr,
  input  wire logic [1:0]           sel_idx,
  input  wire logic [5:0]           sel_code,
  // Frequency comparison
  input  wire logic [FREQ_W-1:0]    ramp_freq,
  input  wire logic [FREQ_W-1:0]    freq_detect,
  // Status sources
  input  otfs_pkg::otfs_status_t    status,
  input  otfs_pkg::otfs_card_t      card,
  // Selector readback and terminals
  output logic [TERMS-1:0][5:0]     sel_code_out,
  output logic [TERMS-1:0]          term_out
);

  logic [TERMS-1:0][5:0] sel_r;
  logic [TERMS-1:0][5:0] sel_nxt;
  logic [TERMS-1:0]      term_r;
  logic [TERMS-1:0]      term_nxt;
  logic                  freq_above;

  // Reset value of a selector by terminal index
  function automatic logic [5:0] rst_sel(input int unsigned idx);
    case (idx)
      otfs_pkg::TERM_OC:  rst_sel = otfs_pkg::RST_SEL_OC;
      otfs_pkg::TERM_PLS: rst_sel = otfs_pkg::RST_SEL_PLS;
      otfs_pkg::TERM_RA:  rst_sel = otfs_pkg::RST_SEL_RA;
      otfs_pkg::TERM_RB:  rst_sel = otfs_pkg::RST_SEL_RB;
      default:            rst_sel = otfs_pkg::FC_INVALID;
    endcase
  endfunction

  // Strict compare; equal frequency does not count as reached
  assign freq_above = (ramp_freq > freq_detect); // R05

  // Selector write: one terminal per write, others hold
  always_comb
  begin
    sel_nxt = sel_r;
    if (sel_wr && (32'(sel_idx) < TERMS))
    begin
      sel_nxt[sel_idx] = sel_code; // R01
    end
  end

  // Selector storage
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      for (int unsigned i = 0; i < TERMS; i++)
      begin
        sel_r[i] <= rst_sel(i); // R02
      end
    end
    else
    begin
      sel_r <= sel_nxt;
    end
  end

  // One independent selector per terminal; codes may repeat freely
  for (genvar g = 0; g < TERMS; g++)
  begin : g_term
    otfs_sel u_sel
    (
      .code       (sel_r[g]),
      .status     (status),
      .card       (card),
      .freq_above (freq_above),
      .level      (term_nxt[g])
    ); // R01
  end

  // Register terminals so they never glitch on a code change
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      term_r <= '0;
    end
    else
    begin
      term_r <= term_nxt;
    end
  end

  assign term_out     = term_r;
  assign sel_code_out = sel_r;

  // Assertions
  sequence s_sel_bus;
    sel_r[0] == otfs_pkg::FC_BUS_VOUT;
  endsequence

  reset_sel_a: assert property (@(posedge ref_clk) // R02
    $rose(rst_n) |-> (sel_r[otfs_pkg::TERM_RA] == otfs_pkg::FC_RUNNING)
                     && (sel_r[otfs_pkg::TERM_RB] == otfs_pkg::FC_FAULT))
    else $error("relay selectors wrong after reset");

  bus_mirror_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R03
    s_sel_bus ##1 s_sel_bus |-> term_r[0] == $past(status.bus_vout))
    else $error("bus virtual output not mirrored");

  switch_done_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R04
    (sel_r[0] == otfs_pkg::FC_SWITCH) ##1 (sel_r[0] == otfs_pkg::FC_SWITCH)
    |-> term_r[0] == $past(status.switch_done))
    else $error("switch-over output wrong");

  freq_cmp_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R05
    (sel_r[1] == otfs_pkg::FC_ANY_FREQ) ##1 (sel_r[1] == otfs_pkg::FC_ANY_FREQ)
    |-> term_r[1] == ($past(ramp_freq) > $past(freq_detect)))
    else $error("frequency compare wrong");

  card_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R06
    (sel_r[2] == otfs_pkg::FC_CARD_RD) ##1 (sel_r[2] == otfs_pkg::FC_CARD_RD)
    |-> term_r[2] == $past(card.card_relay_out_d))
    else $error("card output not passed");

  stop_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
    (sel_r[3] == otfs_pkg::FC_STOP_ZERO) ##1 (sel_r[3] == otfs_pkg::FC_STOP_ZERO)
    |-> term_r[3] == ($past(status.stopped) | $past(status.zero_speed)))
    else $error("stop or zero speed wrong");

  disconn_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R11
    (sel_r[0] == otfs_pkg::FC_DISCONN) && !status.disconn_en |=> !term_r[0])
    else $error("disconnection shown while disabled");

  dia_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
    (sel_r[1] == otfs_pkg::FC_DIA_MAX) && !status.tension_run |=> !term_r[1])
    else $error("max diameter shown outside tension run");

  fire_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R15
    (sel_r[2] == otfs_pkg::FC_FIRE) && status.fire_mode |=> term_r[2])
    else $error("fire mode not shown");

  reserved_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R16
    (sel_r[3] == 6'h23) || ((sel_r[3] >= 6'h26) && (sel_r[3] <= 6'h28))
    || (sel_r[3] > otfs_pkg::FC_FIRE) |=> !term_r[3])
    else $error("reserved code drove terminal");

endmodule

// [core/otfs_pkg.sv]
package otfs_pkg;

  // Width of a function code
  localparam int unsigned CODE_W = 6;
  // Number of output terminals
  localparam int unsigned TERM_N = 4;
  // Terminal order: index of each terminal
  localparam int unsigned TERM_OC  = 0;
  localparam int unsigned TERM_PLS = 1;
  localparam int unsigned TERM_RA  = 2;
  localparam int unsigned TERM_RB  = 3;

  // Function codes
  localparam logic [5:0] FC_INVALID   = 6'h00;
  localparam logic [5:0] FC_RUNNING   = 6'h01;
  localparam logic [5:0] FC_FAULT     = 6'h05;
  localparam logic [5:0] FC_BUS_VOUT  = 6'h22;
  localparam logic [5:0] FC_SWITCH    = 6'h24;
  localparam logic [5:0] FC_ANY_FREQ  = 6'h25;
  localparam logic [5:0] FC_CARD_OCA  = 6'h29;
  localparam logic [5:0] FC_CARD_OCB  = 6'h2A;
  localparam logic [5:0] FC_CARD_PLS  = 6'h2B;
  localparam logic [5:0] FC_CARD_RA   = 6'h2C;
  localparam logic [5:0] FC_CARD_RB   = 6'h2D;
  localparam logic [5:0] FC_CARD_RC   = 6'h2E;
  localparam logic [5:0] FC_CARD_RD   = 6'h2F;
  localparam logic [5:0] FC_OH_PT100  = 6'h30;
  localparam logic [5:0] FC_OH_PT1000 = 6'h31;
  localparam logic [5:0] FC_OH_AIO    = 6'h32;
  localparam logic [5:0] FC_STOP_ZERO = 6'h33;
  localparam logic [5:0] FC_DISCONN   = 6'h34;
  localparam logic [5:0] FC_DIA_SET   = 6'h35;
  localparam logic [5:0] FC_DIA_MAX   = 6'h36;
  localparam logic [5:0] FC_DIA_MIN   = 6'h37;
  localparam logic [5:0] FC_FIRE      = 6'h38;

  // Reset value of each terminal selector
  localparam logic [5:0] RST_SEL_OC  = FC_INVALID;
  localparam logic [5:0] RST_SEL_PLS = FC_INVALID;
  localparam logic [5:0] RST_SEL_RA  = FC_RUNNING;
  localparam logic [5:0] RST_SEL_RB  = FC_FAULT;

  // Frequency width
  localparam int unsigned FREQ_W = 16;

  // Status conditions from the control core
  typedef struct packed {
    logic running;
    logic fault;
    logic bus_vout;
    logic switch_done;
    logic stopped;
    logic zero_speed;
    logic oh_pt100;
    logic oh_pt1000;
    logic oh_aio;
    logic disconn_det;
    logic disconn_en;
    logic tension_run;
    logic dia_set;
    logic dia_max;
    logic dia_min;
    logic fire_mode;
  } otfs_status_t;

  // Outputs of the programmable expansion card
  typedef struct packed {
    logic card_open_collector_out_a;
    logic card_open_collector_out_b;
    logic card_pulse_out;
    logic relay_out_a;
    logic relay_out_b;
    logic card_relay_out_c;
    logic card_relay_out_d;
  } otfs_card_t;

endpackage

// [core/otfs_sel.sv]
`timescale 1ns/1ns
// Combinational source selector for one terminal
module otfs_sel
(
  // Selection
  input  wire logic [5:0]           code,
  // Sources
  input  otfs_pkg::otfs_status_t    status,
  input  otfs_pkg::otfs_card_t      card,
  input  wire logic                 freq_above,
  // Result
  output logic                      level
);

  // Map each code to its source; every unlisted code is inactive
  always_comb
  begin
    level = 1'b0;
    case (code)
      otfs_pkg::FC_RUNNING:   level = status.running;
      otfs_pkg::FC_FAULT:     level = status.fault;
      otfs_pkg::FC_BUS_VOUT:  level = status.bus_vout;    // R03
      otfs_pkg::FC_SWITCH:    level = status.switch_done; // R04
      otfs_pkg::FC_ANY_FREQ:  level = freq_above;         // R05
      otfs_pkg::FC_CARD_OCA:  level = card.card_open_collector_out_a; // R06
      otfs_pkg::FC_CARD_OCB:  level = card.card_open_collector_out_b; // R06
      otfs_pkg::FC_CARD_PLS:  level = card.card_pulse_out;   // R06
      otfs_pkg::FC_CARD_RA:   level = card.relay_out_a;      // R06
      otfs_pkg::FC_CARD_RB:   level = card.relay_out_b;      // R06
      otfs_pkg::FC_CARD_RC:   level = card.card_relay_out_c; // R06
      otfs_pkg::FC_CARD_RD:   level = card.card_relay_out_d; // R06
      otfs_pkg::FC_OH_PT100:  level = status.oh_pt100;    // R07
      otfs_pkg::FC_OH_PT1000: level = status.oh_pt1000;   // R08
      otfs_pkg::FC_OH_AIO:    level = status.oh_aio;      // R09
      otfs_pkg::FC_STOP_ZERO: level = status.stopped | status.zero_speed; // R10
      otfs_pkg::FC_DISCONN:   level = status.disconn_det & status.disconn_en; // R11
      otfs_pkg::FC_DIA_SET:   level = status.dia_set & status.tension_run; // R12
      otfs_pkg::FC_DIA_MAX:   level = status.dia_max & status.tension_run; // R13
      otfs_pkg::FC_DIA_MIN:   level = status.dia_min & status.tension_run; // R14
      otfs_pkg::FC_FIRE:      level = status.fire_mode;   // R15
      default:                level = 1'b0;               // R16
    endcase
  end

endmodule

// [test/otfs_load.sv]
`timescale 1ns/1ns
// Loads on the output terminals: each coil follows its drive one cycle later
module otfs_load
#(
  parameter int unsigned TERMS = 4
)
(
  // Clock
  input  wire logic             ref_clk,
  // Terminal drive
  input  wire logic [TERMS-1:0] term_out,
  // Coil state
  output logic      [TERMS-1:0] coil_on
);
  // A relay pulls in after the drive settles; nothing is fed back to the block
  always_ff @(posedge ref_clk)
  begin
    coil_on <= term_out;
  end
endmodule

// [test/output_terminal_function_select_tb.sv]
`timescale 1ns/1ns
// Self-checking bench for the terminal function selector
module output_terminal_function_select_tb;
  // Design inputs and outputs
  logic                   ref_clk;
  logic                   rst_n;
  logic                   sel_wr;
  logic [1:0]             sel_idx;
  logic [5:0]             sel_code;
  logic [15:0]            ramp_freq;
  logic [15:0]            freq_detect;
  otfs_pkg::otfs_status_t status;
  otfs_pkg::otfs_card_t   card;
  logic [3:0][5:0]        sel_code_out;
  logic [3:0]             term_out;
  logic [3:0]             coil_on;
  // Bench state
  logic [5:0]             code_q [4];
  logic [31:0]            r;
  int                     seed;
  int                     fail_count;
  int                     checked;

  otfs_top #(.TERMS(4), .FREQ_W(16)) otfs_top_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .sel_wr(sel_wr), .sel_idx(sel_idx), .sel_code(sel_code), .ramp_freq(ramp_freq),
    .freq_detect(freq_detect), .status(status), .card(card),
    .sel_code_out(sel_code_out), .term_out(term_out));
  otfs_load #(.TERMS(4)) otfs_load_inst (.ref_clk(ref_clk), .term_out(term_out),
    .coil_on(coil_on));

  // Clock at 250 MHz
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Expected terminal level for a code, from the inputs being driven
  function automatic logic fx(input logic [5:0] c);
    case (c)
      6'h01: fx = status.running;
      6'h05: fx = status.fault;
      6'h22: fx = status.bus_vout;
      6'h24: fx = status.switch_done;
      6'h25: fx = ramp_freq > freq_detect;
      6'h29: fx = card.card_open_collector_out_a;
      6'h2A: fx = card.card_open_collector_out_b;
      6'h2B: fx = card.card_pulse_out;
      6'h2C: fx = card.relay_out_a;
      6'h2D: fx = card.relay_out_b;
      6'h2E: fx = card.card_relay_out_c;
      6'h2F: fx = card.card_relay_out_d;
      6'h30: fx = status.oh_pt100;
      6'h31: fx = status.oh_pt1000;
      6'h32: fx = status.oh_aio;
      6'h33: fx = status.stopped | status.zero_speed;
      6'h34: fx = status.disconn_det & status.disconn_en;
      6'h35: fx = status.dia_set & status.tension_run;
      6'h36: fx = status.dia_max & status.tension_run;
      6'h37: fx = status.dia_min & status.tension_run;
      6'h38: fx = status.fire_mode;
      default: fx = 1'b0;
    endcase
  endfunction

  // Compare and count
  task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // One selector write, taken at the next edge
  task automatic wr(input logic [1:0] idx, input logic [5:0] code);
    sel_wr <= 1'b1;
    sel_idx <= idx;
    sel_code <= code;
    @(posedge ref_clk);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog so a stuck run still reaches the verdict
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    test_done();
  end

  // Reset, then codes 34 to 63 written to all terminals one after another, then random mixes
  initial
  begin
    seed = 32'h395F262B;
    fail_count = 0;
    checked = 0;
    rst_n = 1'b0;
    sel_wr = 1'b0;
    sel_idx = 2'h0;
    sel_code = 6'h00;
    ramp_freq = 16'h0000;
    freq_detect = 16'h0000;
    status = '0;
    card = '0;
    code_q = '{6'h00, 6'h00, 6'h01, 6'h05};
    repeat (5) @(posedge ref_clk);
    // Release after five low edges; reset values must still stand
    rst_n <= 1'b1;
    #1;
    for (int t = 0; t < 4; t++)
    begin
      chk(sel_code_out[t], code_q[t]);
      chk({5'h00, term_out[t]}, 6'h00);
    end
    for (int i = 0; i < 160; i++)
    begin
      @(posedge ref_clk);
      // Pass 0 keeps the reset selectors; 1..30 share one code over all terminals
      // Pass 80 resets mid-run, so the selectors must fall back to their defaults
      if (i == 80)
      begin
        rst_n <= 1'b0;
        code_q = '{6'h00, 6'h00, 6'h01, 6'h05};
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
      end
      else if (i > 0)
        for (int t = 0; t < 4; t++)
        begin
          r = $random(seed);
          code_q[t] = (i <= 30) ? 6'(i + 33) : 6'(34 + r[7:0] % 30);
          wr(2'(t), code_q[t]);
        end
      r = $random(seed);
      sel_wr <= 1'b0;
      status <= r[15:0];
      card <= r[22:16];
      ramp_freq <= {8'h00, r[31:24]};
      // Every third pass puts the detection value equal to the ramp frequency
      freq_detect <= {8'h00, (i % 3 == 0) ? r[31:24] : r[7:0]};
      repeat (3) @(posedge ref_clk);
      #1;
      for (int t = 0; t < 4; t++)
      begin
        chk(sel_code_out[t], code_q[t]);
        chk({5'h00, term_out[t]}, {5'h00, fx(code_q[t])});
        chk({5'h00, coil_on[t]}, {5'h00, fx(code_q[t])});
      end
      $display("test %0d done", i);
    end
    test_done();
  end
endmodule
